/* File: tdsk_read_deskew.v */
// Purpose: Per-track read deskew timers, read bus lines and amplitude error flag
// Assumes: All inputs synchronous to mclk; read pulses are single-cycle events
// Notes:   Gating polarity follows motion direction; see hand-over for the choice
//
// How it works
// - Forward timer sets on track read pulse with access, forward motion, test off
// - Forward timer clears itself one calibrated delay, 2 to 8 us, after setting
// - Seven reverse timers mirror forward ones, gated by reverse motion instead
// - Amplitude error flag sets on low amplitude while accessed, clears after 10 us
// - Amplitude low means amplifier sample below the threshold level
// - Test read term is access and test and the track's write state
`timescale 1ns/1ns
`include "tdsk_consts.vh"
module tdsk_read_deskew #(
  parameter NTRK      = `TDSK_NUM_TRACKS,
  parameter DESKEW_NS = `TDSK_DESKEW_DEF_NS,
  parameter AMP_W     = `TDSK_AMP_W
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rstn,
  // Unit state
  input  wire             unit_access,
  input  wire             forward_motion,
  input  wire             reverse_motion,
  input  wire             test_mode,
  // Read amplifier side
  input  wire [NTRK-1:0]  track_read_pulse,
  input  wire [AMP_W-1:0] amp_sample,
  input  wire [AMP_W-1:0] amp_threshold,
  // Write side state for loopback
  input  wire [NTRK-1:0]  track_write_state,
  // Read bus lines and error flag
  output reg  [NTRK-1:0]  track_read_line,
  output reg              amplitude_error_flag,
  output wire             track2_read_line,
  output wire             track6_write_state_seen,
  // Buffered read bus words
  output wire             word_valid,
  input  wire             word_ready,
  output wire [NTRK-1:0]  word_data,
  output wire             word_stall
);

  localparam CW = `TDSK_CNT_W;

  // Delay kept inside the calibration window whatever the parameter says
  localparam DLY_NS = (DESKEW_NS < `TDSK_DESKEW_MIN_NS) ? `TDSK_DESKEW_MIN_NS :
                      (DESKEW_NS > `TDSK_DESKEW_MAX_NS) ? `TDSK_DESKEW_MAX_NS : DESKEW_NS;

  // Cycle counts from a time in ns, never below one cycle
  function integer ns_to_cyc;
    input integer ns;
    integer c;
    begin
      c = (ns * `TDSK_CLK_MHZ) / 1000;
      ns_to_cyc = (c < 1) ? 1 : c;
    end
  endfunction

  localparam integer DSK_CYC = ns_to_cyc(DLY_NS);
  localparam integer AE_CYC  = ns_to_cyc(`TDSK_AMP_ERR_NS);
  localparam integer DSK_LAST = DSK_CYC - 1;
  localparam integer AE_LAST  = AE_CYC - 1;
  localparam [CW-1:0] DSK_LOAD = DSK_LAST[CW-1:0];
  localparam [CW-1:0] AE_LOAD  = AE_LAST[CW-1:0];

  // Set conditions, forward timers at 0..NTRK-1, reverse above
  wire [2*NTRK-1:0] timer_set;
  wire [2*NTRK-1:0] timer_on;
  wire [NTRK-1:0]   fwd_on;
  wire [NTRK-1:0]   rev_on;
  wire [NTRK-1:0]   test_term;
  wire [NTRK-1:0]   next_read_line;
  wire              fwd_gate;
  wire              rev_gate;
  wire              amp_low;

  // Test mode blocks live pulses from setting timers; timers already running still reach the bus with the loopback
  assign fwd_gate = unit_access & forward_motion & ~test_mode;
  assign rev_gate = unit_access & reverse_motion & ~test_mode;

  assign timer_set[NTRK-1:0]      = track_read_pulse & {NTRK{fwd_gate}};
  assign timer_set[2*NTRK-1:NTRK] = track_read_pulse & {NTRK{rev_gate}};

  assign fwd_on = timer_on[NTRK-1:0];
  assign rev_on = timer_on[2*NTRK-1:NTRK];

  // Loopback of the write side onto the read bus
  assign test_term = track_write_state & {NTRK{unit_access & test_mode}};

  assign next_read_line = fwd_on | rev_on | test_term;

  // One one-shot per timer; all share the calibrated delay
  genvar g;
  generate
    for (g = 0; g < 2*NTRK; g = g + 1)
    begin : g_timer
      reg          on;
      reg [CW-1:0] cnt;
      assign timer_on[g] = on;
      always @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          on  <= `TDSK_TIMER_RST;
          cnt <= {CW{1'b0}};
        end
        else if (timer_set[g] & (~on | (cnt == {CW{1'b0}})))
        begin
          // A set landing on the expiry cycle restarts rather than being lost
          on  <= 1'b1;
          cnt <= DSK_LOAD;
        end
        else if (on)
        begin
          if (cnt == {CW{1'b0}})
            on <= 1'b0;
          else
            cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  // Amplitude detection and error flag
  assign amp_low = (amp_sample < amp_threshold);

  reg [CW-1:0] ae_cnt;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      amplitude_error_flag <= `TDSK_FLAG_RST;
      ae_cnt               <= {CW{1'b0}};
    end
    else if (amp_low & unit_access & (~amplitude_error_flag | (ae_cnt == {CW{1'b0}})))
    begin
      // Non-retriggerable; a new set is taken only at or after expiry
      amplitude_error_flag <= 1'b1;
      ae_cnt               <= AE_LOAD;
    end
    else if (amplitude_error_flag)
    begin
      if (ae_cnt == {CW{1'b0}})
        amplitude_error_flag <= 1'b0;
      else
        ae_cnt <= ae_cnt - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Read bus lines registered so the outputs come from flops
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      track_read_line <= {NTRK{1'b0}};
    else
      track_read_line <= next_read_line;
  end

  assign track2_read_line        = track_read_line[1];
  assign track6_write_state_seen = test_term[5];

  // Word stream: push the bus lines into the buffer whenever they differ from the last word pushed
  reg  [NTRK-1:0] last_pushed;
  wire            buf_in_ready;
  wire            push_req;

  // A stalled change stays pending here, so the final state is never lost
  assign push_req   = (track_read_line != last_pushed);
  assign word_stall = push_req & ~buf_in_ready;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      last_pushed <= {NTRK{1'b0}};
    else if (push_req & buf_in_ready)
      last_pushed <= track_read_line;
  end

  tdsk_skid_buf #(
    .WIDTH (NTRK),
    .DEPTH (2)
  ) u_buf (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (push_req),
    .in_ready  (buf_in_ready),
    .in_data   (track_read_line),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

endmodule // tdsk_read_deskew

/* File: tdsk_consts.vh */
// Purpose: Shared constants for the tape read deskew timer block
// Assumes: 50 MHz system clock
// Notes:   Times in ns; cycle counts are derived in the modules
`ifndef TDSK_CONSTS_VH
`define TDSK_CONSTS_VH

// Clock
`define TDSK_CLK_MHZ        50
// Tracks: index 0..5 carry data tracks 1..6, index 6 is parity
`define TDSK_NUM_TRACKS     7
`define TDSK_PARITY_IDX     6
// Deskew delay, calibrated inside the window below
`define TDSK_DESKEW_MIN_NS  2000
`define TDSK_DESKEW_MAX_NS  8000
`define TDSK_DESKEW_DEF_NS  5000
// Amplitude error flag hold time
`define TDSK_AMP_ERR_NS     10000
// Counter and sample widths
`define TDSK_CNT_W          10
`define TDSK_AMP_W          8
// Reset values
`define TDSK_TIMER_RST      1'b0
`define TDSK_FLAG_RST       1'b0

`endif

/* File: tdsk_skid_buf.v */
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Accepts and delivers one word per cycle when neither side stalls
`timescale 1ns/1ns
module tdsk_skid_buf #(
  parameter WIDTH = 7,
  parameter DEPTH = 2
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rstn,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [1:0]       count;
  reg             wr_ptr;
  reg             rd_ptr;

  wire push;
  wire pop;

  // Full only at two entries, so the source sees a stall honestly
  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      count  <= 2'd0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        count <= count + 2'd1;
      else if (pop & ~push)
        count <= count - 2'd1;
    end
  end

  // Storage has no reset; it is never read while empty
  always @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule // tdsk_skid_buf

/* File: tdsk_chk_sva.sv */
// Purpose: Port assertions for tdsk_read_deskew
// Assumes: DESKEW_NS a multiple of the 20 ns period
// Notes: Deskew length watched on track 0 only, so no retrigger there
`timescale 1ns/1ns
module tdsk_chk_sva #(
  parameter DESKEW_NS = 5000
) (
  input wire       mclk,
  input wire       rstn,
  input wire       unit_access,
  input wire       forward_motion,
  input wire       reverse_motion,
  input wire       test_mode,
  input wire [6:0] track_read_pulse,
  input wire [7:0] amp_sample,
  input wire [7:0] amp_threshold,
  input wire [6:0] track_write_state,
  input wire [6:0] track_read_line,
  input wire       amplitude_error_flag,
  input wire       track6_write_state_seen
);
  reg [9:0] hcnt;
  reg [9:0] acnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      hcnt <= 10'h000;
      acnt <= 10'h000;
    end
    else
    begin
      hcnt <= track_read_line[0] ? hcnt + 10'h001 : 10'h000;
      acnt <= amplitude_error_flag ? acnt + 10'h001 : 10'h000;
    end
  end
  fwd_set_a: assert property (|track_read_pulse && unit_access && forward_motion && !test_mode
    |-> ##2 &(track_read_line | ~$past(track_read_pulse, 2))) else $error("forward timer not set");
  rev_set_a: assert property (|track_read_pulse && unit_access && reverse_motion && !test_mode
    |-> ##2 &(track_read_line | ~$past(track_read_pulse, 2))) else $error("reverse timer not set");
  deskew_len_a: assert property ($fell(track_read_line[0]) && !test_mode |-> hcnt == DESKEW_NS / 20)
    else $error("deskew time wrong");
  amp_set_a: assert property (amp_sample < amp_threshold && unit_access |=> amplitude_error_flag)
    else $error("amplitude flag not set");
  amp_hold_a: assert property ($fell(amplitude_error_flag) |-> acnt == 10'h1F4)
    else $error("amplitude hold wrong");
  test_term_a: assert property (track6_write_state_seen == (unit_access && test_mode && track_write_state[5]))
    else $error("test term wrong");
  bus_or_a: assert property (unit_access && test_mode |=> &(track_read_line | ~$past(track_write_state)))
    else $error("test term not on bus");
endmodule // tdsk_chk_sva
bind tdsk_read_deskew tdsk_chk_sva #(.DESKEW_NS(DESKEW_NS)) chk_u (.mclk, .rstn, .unit_access, .forward_motion,
  .reverse_motion, .test_mode, .track_read_pulse, .amp_sample, .amp_threshold, .track_write_state,
  .track_read_line, .amplitude_error_flag, .track6_write_state_seen);

/* File: tdsk_amp_model.sv */
// Purpose: Stand-in for the read amplifiers and the word sink
// Assumes: Tasks entered at a falling edge
// Notes: Pulses last one cycle; amplitude idles above threshold
`timescale 1ns/1ns
module tdsk_amp_model (
  input  wire       mclk,
  input  wire       sink_hold,
  output wire       word_ready,
  output reg  [6:0] track_read_pulse = 7'h00,
  output reg  [7:0] amp_sample = 8'h80
);
  assign word_ready = !sink_hold;
  task fire(input [6:0] m, input [7:0] a);
  begin
    {track_read_pulse, amp_sample} = {m, a};
    @(negedge mclk);
    {track_read_pulse, amp_sample} = 15'h0080;
  end
  endtask
endmodule // tdsk_amp_model

/* File: tape_read_deskew_timers_tb.sv */
// Purpose: Self-checking bench for tdsk_read_deskew
// Assumes: Deskew cut to 2000 ns, 100 cycles
// Notes: Inputs move on falling edges
`timescale 1ns/1ns
module tape_read_deskew_timers_tb;
  reg        mclk = 1'b0;
  reg        rstn = 1'b0;
  reg        unit_access = 1'b0;
  reg        forward_motion = 1'b0;
  reg        reverse_motion = 1'b0;
  reg        test_mode = 1'b0;
  reg        sink_hold = 1'b0;
  reg  [6:0] track_write_state = 7'h00;
  reg  [7:0] amp_threshold = 8'h40;
  wire [6:0] track_read_pulse;
  wire [6:0] track_read_line;
  wire [6:0] word_data;
  wire [7:0] amp_sample;
  wire       amplitude_error_flag;
  wire       track2_read_line;
  wire       track6_write_state_seen;
  wire       word_valid;
  wire       word_ready;
  wire       word_stall;
  wire [7:0] mon = {amplitude_error_flag, track_read_line};
  integer    n_fail = 0;
  integer    n_tests = 0;
  integer    cyc = 0;
  integer    n;
  always #10 mclk = ~mclk;
  tdsk_read_deskew #(.DESKEW_NS(2000)) dut_u (.mclk, .rstn, .unit_access, .forward_motion, .reverse_motion,
    .test_mode, .track_read_pulse, .amp_sample, .amp_threshold, .track_write_state, .track_read_line,
    .amplitude_error_flag, .track2_read_line, .track6_write_state_seen, .word_valid, .word_ready,
    .word_data, .word_stall);
  tdsk_amp_model amp_u (.mclk, .sink_hold, .word_ready, .track_read_pulse, .amp_sample);
  task finish_test;
  begin
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end
  task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // Counts falling edges while the watched bit stays high
  task hi_len(input integer b);
  begin
    n = 0;
    repeat (4) if (!mon[b]) @(negedge mclk);
    while (mon[b] && n < 600)
    begin
      n = n + 1;
      @(negedge mclk);
    end
  end
  endtask
  task t_dir(input fwd);
  begin
    {unit_access, forward_motion, reverse_motion} = {1'b1, fwd, !fwd};
    amp_u.fire(7'h7F, 8'h80);
    @(negedge mclk);
    check("lines", {track2_read_line, track_read_line}, 9'h0FF);
    hi_len(0);
    check("deskew", n[8:0], 9'h064);
    $display("t_dir %0d done", fwd);
  end
  endtask
  task t_gate;
  begin
    unit_access = 1'b0;
    amp_u.fire(7'h7F, 8'h3F);
    repeat (2) @(negedge mclk);
    check("no access", mon, 9'h000);
    {unit_access, test_mode} = 2'b11;
    amp_u.fire(7'h7F, 8'h40);
    repeat (2) @(negedge mclk);
    check("test gate", mon, 9'h000);
    track_write_state = 7'h20;
    repeat (2) @(negedge mclk);
    check("loop", {track6_write_state_seen, track_read_line}, 9'h0A0);
    {test_mode, track_write_state} = 8'h00;
    repeat (3) @(negedge mclk);
    $display("t_gate done");
  end
  endtask
  task t_amp;
  begin
    amp_u.fire(7'h00, 8'h3F);
    hi_len(7);
    check("amp hold", n[8:0], 9'h1F4);
    $display("t_amp done");
  end
  endtask
  task pop(input [6:0] e);
  begin
    check("word", {word_valid, word_data}, {1'b1, e});
    sink_hold = 1'b0;
    @(negedge mclk);
    sink_hold = 1'b1;
    repeat (2) @(negedge mclk);
  end
  endtask
  // Three line changes against a stalled sink: the third must wait
  task t_buf;
  begin
    {unit_access, forward_motion, reverse_motion, sink_hold} = 4'hD;
    amp_u.fire(7'h01, 8'h80);
    repeat (3) @(negedge mclk);
    amp_u.fire(7'h02, 8'h80);
    repeat (3) @(negedge mclk);
    amp_u.fire(7'h04, 8'h80);
    repeat (3) @(negedge mclk);
    check("stall", word_stall, 9'h001);
    pop(7'h01);
    pop(7'h03);
    pop(7'h07);
    check("empty", word_valid, 9'h000);
    sink_hold = 1'b0;
    repeat (120) @(negedge mclk);
    $display("t_buf done");
  end
  endtask
  // Mid-run reset clears running timers, the flag and the buffer
  task t_rst;
  begin
    {unit_access, forward_motion, reverse_motion} = 3'b110;
    amp_u.fire(7'h7F, 8'h3F);
    repeat (2) @(negedge mclk);
    check("armed", {1'b0, mon}, 9'h0FF);
    rstn = 1'b0;
    @(negedge mclk);
    check("in reset", {word_valid, mon}, 9'h000);
    rstn = 1'b1;
    @(negedge mclk);
    check("after reset", {word_valid, mon}, 9'h000);
    $display("t_rst done");
  end
  endtask
  initial
  begin
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    t_dir(1'b1);
    t_dir(1'b0);
    t_gate;
    t_amp;
    t_buf;
    t_rst;
    finish_test;
  end
endmodule // tape_read_deskew_timers_tb
